// ### hdl/tcc_top.v
// Contract
// - 16-bit counter increments per counting edge.
// - Wrap from maximum sets overflow flag.
// - Counter readable; trigger zeroes at next edge.
// - Block routing picks pin or other line A.
// - Eight clock sources, optional edge inversion.
// - Gate input lets edges through while high.
// - Enable/disable commands, configurable auto-disable, status.
// - Triggers start, configured events stop clock.
// - Mode bit picks capture or waveform directions.
// - Software trigger and block-wide synchronous trigger.
// - Compare C match may trigger reset.
// - Waveform external event gated by trigger enable.
// - Triggers act at next counting edge.
// - Capture A and B on line A edges.
// - A and B load in alternating order.
// - Unread overwrite sets load overrun flag.
// - Capture trigger line and edge select.
// - Compares A, C drive line A; B, C line B.
// - Profile 00 free-runs up, no C trigger.
// - Profile 10 counts up to C, resets.
// - Profile 01 up-down full range, trigger reverses.
// - Profile 11 up-down to C, trigger reverses.
//
// Decided for this implementation: the plain strobed port and the register offsets.
`include "tcc_map.vh"

module tcc_top (
    // Clock, reset and freeze
    input wire clk,
    input wire rst,
    input wire ce,
    // Register port
    input wire [`TCC_ADDR_W-1:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    output wire [31:0] rdata,
    // Internal clock levels from the prescaler, same clock domain
    input wire [4:0] internal_clock,
    // External clock pins
    input wire [2:0] external_clock_pin,
    // Channel I/O line A per channel
    input wire [2:0] channel_io_a_i,
    output wire [2:0] channel_io_a_o,
    output wire [2:0] channel_io_a_oe,
    // Channel I/O line B per channel
    input wire [2:0] channel_io_b_i,
    output wire [2:0] channel_io_b_o,
    output wire [2:0] channel_io_b_oe
);

    // ----------------------------------------------------------------
    // Helper functions
    // ----------------------------------------------------------------

    // Edge field: 00 none, 01 rising, 10 falling, 11 both.
    function edge_hit;
        input [1:0] sel;
        input rise;
        input fall;
        begin
            edge_hit = (sel[0] & rise) | (sel[1] & fall);
        end
    endfunction

    // Output action: 00 keep, 01 set, 10 clear, 11 toggle.
    function out_act;
        input cur;
        input hit;
        input [1:0] act;
        begin
            if (!hit || act == 2'h0) begin
                out_act = cur;
            end else if (act == 2'h1) begin
                out_act = 1'b1;
            end else if (act == 2'h2) begin
                out_act = 1'b0;
            end else begin
                out_act = ~cur;
            end
        end
    endfunction

    // Block routing of one external clock: pin, none, or one of two line A levels.
    function xc_route;
        input [1:0] sel;
        input pin;
        input line_x;
        input line_y;
        begin
            if (sel == 2'h0) begin
                xc_route = pin;
            end else if (sel == 2'h2) begin
                xc_route = line_x;
            end else if (sel == 2'h3) begin
                xc_route = line_y;
            end else begin
                xc_route = 1'b0;
            end
        end
    endfunction

    // ----------------------------------------------------------------
    // Pin synchronisation and block routing
    // ----------------------------------------------------------------
    wire [2:0] pin_clk_s;
    wire [2:0] line_a_s;
    wire [2:0] line_b_s;
    reg [2:0] xc_prev_q;
    reg [2:0] line_a_prev_q;
    reg [2:0] line_b_prev_q;
    reg [5:0] bmr_q;
    reg [31:0] rdata_q;
    wire [2:0] xc;
    wire [2:0] xc_rise;
    wire [2:0] xc_fall;
    wire [2:0] a_rise;
    wire [2:0] a_fall;
    wire [2:0] b_rise;
    wire [2:0] b_fall;
    wire [2:0] tick_w;
    wire [95:0] ch_rd_w;
    wire blk_wr = wr && (addr[7:6] == `TCC_CH_BLOCK);
    wire sync_cmd = wr && (addr == `TCC_ADDR_BCR) && wdata[`TCC_BCR_SYNC];

    tcc_sync2 #(
        .W(9)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .async_in({channel_io_b_i, channel_io_a_i, external_clock_pin}),
        .sync_out({line_b_s, line_a_s, pin_clk_s})
    );

    // route pins or chained line A
    assign xc[0] = xc_route(bmr_q[1:0], pin_clk_s[0], line_a_s[1], line_a_s[2]);
    assign xc[1] = xc_route(bmr_q[3:2], pin_clk_s[1], line_a_s[0], line_a_s[2]);
    assign xc[2] = xc_route(bmr_q[5:4], pin_clk_s[2], line_a_s[0], line_a_s[1]);

    assign xc_rise = xc & ~xc_prev_q;
    assign xc_fall = ~xc & xc_prev_q;
    assign a_rise = line_a_s & ~line_a_prev_q;
    assign a_fall = ~line_a_s & line_a_prev_q;
    assign b_rise = line_b_s & ~line_b_prev_q;
    assign b_fall = ~line_b_s & line_b_prev_q;

    // Previous levels for edge detection, and the block routing register.
    always @(posedge clk) begin
        if (rst) begin
            xc_prev_q <= 3'h0;
            line_a_prev_q <= 3'h0;
            line_b_prev_q <= 3'h0;
            bmr_q <= `TCC_RST_BMR;
        end else if (ce) begin
            xc_prev_q <= xc;
            line_a_prev_q <= line_a_s;
            line_b_prev_q <= line_b_s;
            if (wr && addr == `TCC_ADDR_BMR) begin
                bmr_q <= wdata[5:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Channels
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_ch
            reg [15:0] cv_q;
            reg [15:0] cv_d;
            reg [15:0] ra_q;
            reg [15:0] rb_q;
            reg [15:0] rc_q;
            reg [15:0] top;
            reg [31:0] cmr_q;
            reg [`TCC_SR_FLAGS_W-1:0] flags_q;
            reg [31:0] rd_w;
            reg en_q;
            reg run_q;
            reg up_q;
            reg up_d;
            reg ovf_ev;
            reg pend_q;
            reg a_since_q;
            reg a_unread_q;
            reg b_unread_q;
            reg io_a_q;
            reg io_b_q;
            reg oe_a_q;
            reg oe_b_q;
            reg ext_evt;

            wire here = !blk_wr && (addr[7:6] == gi);
            wire [5:0] off = addr[5:0];
            wire wr_ccr = wr && here && off == `TCC_OFF_CCR;
            wire rd_sr = rd && here && off == `TCC_OFF_SR;
            wire rd_ra = rd && here && off == `TCC_OFF_RA;
            wire rd_rb = rd && here && off == `TCC_OFF_RB;
            wire wave = cmr_q[`TCC_CMR_WAVE];
            wire [1:0] prof = cmr_q[`TCC_CMR_PROF];
            wire updown = wave && prof[0];
            wire sw_trg = wr_ccr && wdata[`TCC_CCR_SOFTWARE_TRIGGER_COMMAND];
            wire cmd_dis = wr_ccr && wdata[`TCC_CCR_DIS];
            wire cmd_en = wr_ccr && wdata[`TCC_CCR_EN] && !cmd_dis;
            wire tick = tick_w[gi] && en_q && run_q;
            wire cpa = tick && wave && (cv_q == ra_q);
            wire cpb = tick && wave && (cv_q == rb_q);
            wire cpc = tick && (cv_q == rc_q);
            wire ab_rise = cmr_q[`TCC_CMR_ABSEL] ? a_rise[gi] : b_rise[gi];
            wire ab_fall = cmr_q[`TCC_CMR_ABSEL] ? a_fall[gi] : b_fall[gi];
            wire cap_trg = edge_hit(cmr_q[`TCC_CMR_EDGE], ab_rise, ab_fall);
            wire ext_trg = wave ? (ext_evt && cmr_q[`TCC_CMR_EXTERNAL_EVENT_TRIGGER_ENABLE]) : cap_trg;
            wire cpc_trg = cpc && (wave ? (prof == 2'h2) : cmr_q[`TCC_CMR_COMPARE_C_TRIGGER_ENABLE]);
            wire ext_sw = sw_trg || sync_cmd || ext_trg;
            wire any_trg = ext_sw || cpc_trg;
            wire lda_hit = edge_hit(cmr_q[`TCC_CMR_LDA], a_rise[gi], a_fall[gi]);
            wire ldb_hit = edge_hit(cmr_q[`TCC_CMR_LDB], a_rise[gi], a_fall[gi]);
            wire lda = !wave && lda_hit && !a_since_q;
            wire ldb = !wave && ldb_hit && a_since_q;
            wire stop_ev = wave ? (cpc && cmr_q[`TCC_CMR_STOP]) : (ldb && cmr_q[`TCC_CMR_STOP]);
            wire dis_ev = wave ? (cpc && cmr_q[`TCC_CMR_DIS]) : (ldb && cmr_q[`TCC_CMR_DIS]);
            wire lovr = (lda && a_unread_q) || (ldb && b_unread_q);
            wire [`TCC_SR_FLAGS_W-1:0] set_w = {ext_trg, ldb, lda, cpc, cpb, cpa, lovr, ovf_ev};

            // waveform external event on line B or one external clock
            always @* begin
                if (cmr_q[`TCC_CMR_EXTERNAL_EVENT_SELECT] == 2'h0) begin
                    ext_evt = edge_hit(cmr_q[`TCC_CMR_EDGE], b_rise[gi], b_fall[gi]);
                end else begin
                    ext_evt = edge_hit(cmr_q[`TCC_CMR_EDGE],
                        xc_rise[cmr_q[`TCC_CMR_EXTERNAL_EVENT_SELECT] - 2'h1],
                        xc_fall[cmr_q[`TCC_CMR_EXTERNAL_EVENT_SELECT] - 2'h1]);
                end
            end

            // Next count value; a pending trigger is served at this counting edge.
            always @* begin
                cv_d = cv_q;
                up_d = up_q;
                ovf_ev = 1'b0;
                top = (wave && prof == 2'h3) ? rc_q : `TCC_CNT_MAX;
                if (tick) begin
                    if (pend_q && updown) begin
                        up_d = ~up_q;
                    end
                    if (pend_q && !updown) begin
                        cv_d = `TCC_CNT_ZERO;
                    end else if (cpc_trg) begin
                        cv_d = `TCC_CNT_ZERO;
                    end else if (updown) begin
                        if (up_d && cv_q >= top && cv_q != `TCC_CNT_ZERO) begin
                            up_d = 1'b0;
                            cv_d = cv_q - 16'h0001;
                        end else if (!up_d && cv_q == `TCC_CNT_ZERO) begin
                            up_d = 1'b1;
                            cv_d = cv_q + 16'h0001;
                        end else if (up_d) begin
                            cv_d = cv_q + 16'h0001;
                        end else begin
                            cv_d = cv_q - 16'h0001;
                        end
                    end else begin
                        cv_d = cv_q + 16'h0001;
                        ovf_ev = (cv_q == `TCC_CNT_MAX);
                    end
                end
            end

            // Channel state. Events that set a flag win over a clear by status read.
            always @(posedge clk) begin
                if (rst) begin
                    cv_q <= `TCC_CNT_ZERO;
                    ra_q <= `TCC_CNT_ZERO;
                    rb_q <= `TCC_CNT_ZERO;
                    rc_q <= `TCC_CNT_ZERO;
                    cmr_q <= `TCC_RST_CMR;
                    flags_q <= {`TCC_SR_FLAGS_W{1'b0}};
                    en_q <= 1'b0;
                    run_q <= 1'b1;
                    up_q <= 1'b1;
                    pend_q <= 1'b0;
                    a_since_q <= 1'b0;
                    a_unread_q <= 1'b0;
                    b_unread_q <= 1'b0;
                    io_a_q <= 1'b0;
                    io_b_q <= 1'b0;
                    oe_a_q <= 1'b0;
                    oe_b_q <= 1'b0;
                end else if (ce) begin
                    cv_q <= cv_d;
                    up_q <= up_d;
                    pend_q <= (pend_q && !tick) || ext_sw;
                    if (cmd_dis || dis_ev) begin
                        en_q <= 1'b0;
                    end else if (cmd_en) begin
                        en_q <= 1'b1;
                    end
                    // start and stop only while enabled
                    if (en_q && stop_ev) begin
                        run_q <= 1'b0;
                    end else if (en_q && any_trg) begin
                        run_q <= 1'b1;
                    end
                    if (wr && here && off == `TCC_OFF_CMR) begin
                        cmr_q <= wdata;
                    end
                    if (wr && here && off == `TCC_OFF_RC) begin
                        rc_q <= wdata[15:0];
                    end
                    // capture loads; compare registers writable in waveform
                    if (lda) begin
                        ra_q <= cv_q;
                    end else if (wave && wr && here && off == `TCC_OFF_RA) begin
                        ra_q <= wdata[15:0];
                    end
                    if (ldb) begin
                        rb_q <= cv_q;
                    end else if (wave && wr && here && off == `TCC_OFF_RB) begin
                        rb_q <= wdata[15:0];
                    end
                    if (any_trg || ldb) begin
                        a_since_q <= 1'b0;
                    end else if (lda) begin
                        a_since_q <= 1'b1;
                    end
                    a_unread_q <= lda || (a_unread_q && !rd_ra);
                    b_unread_q <= ldb || (b_unread_q && !rd_rb);
                    flags_q <= set_w | (flags_q & {`TCC_SR_FLAGS_W{~rd_sr}});
                    oe_a_q <= wave;
                    oe_b_q <= wave && (cmr_q[`TCC_CMR_EXTERNAL_EVENT_SELECT] != 2'h0);
                    if (wave) begin
                        io_a_q <= out_act(out_act(io_a_q, cpa, cmr_q[`TCC_CMR_ACPA]),
                            cpc, cmr_q[`TCC_CMR_ACPC]);
                        io_b_q <= out_act(out_act(io_b_q, cpb, cmr_q[`TCC_CMR_BCPB]),
                            cpc, cmr_q[`TCC_CMR_BCPC]);
                    end
                end
            end

            // live counter and status read view
            always @* begin
                rd_w = 32'h0000_0000;
                if (off == `TCC_OFF_CMR) begin
                    rd_w = cmr_q;
                end else if (off == `TCC_OFF_CV) begin
                    rd_w[15:0] = cv_q;
                end else if (off == `TCC_OFF_RA) begin
                    rd_w[15:0] = ra_q;
                end else if (off == `TCC_OFF_RB) begin
                    rd_w[15:0] = rb_q;
                end else if (off == `TCC_OFF_RC) begin
                    rd_w[15:0] = rc_q;
                end else if (off == `TCC_OFF_SR) begin
                    rd_w[`TCC_SR_FLAGS_W-1:0] = flags_q;
                    rd_w[`TCC_SR_CLOCK_ENABLED_FLAG] = en_q;
                end
            end

            assign ch_rd_w[gi*32 +: 32] = rd_w;
            assign channel_io_a_o[gi] = io_a_q;
            assign channel_io_a_oe[gi] = oe_a_q;
            assign channel_io_b_o[gi] = io_b_q;
            assign channel_io_b_oe[gi] = oe_b_q;

            tcc_clksel u_clksel (
                .clk(clk),
                .rst(rst),
                .ce(ce),
                .int_clk(internal_clock),
                .xc(xc),
                .sel(cmr_q[`TCC_CMR_CLKS]),
                .invert(cmr_q[`TCC_CMR_CLOCK_INVERT]),
                .gate_sel(cmr_q[`TCC_CMR_GATE]),
                .tick(tick_w[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------

    // Read data stand only in the cycle after the strobe; unmapped reads give zero.
    always @(posedge clk) begin
        if (rst) begin
            rdata_q <= 32'h0000_0000;
        end else if (ce) begin
            if (!rd) begin
                rdata_q <= 32'h0000_0000;
            end else if (addr == `TCC_ADDR_BMR) begin
                rdata_q <= {26'h0000000, bmr_q};
            end else if (addr[7:6] == `TCC_CH_BLOCK) begin
                rdata_q <= 32'h0000_0000;
            end else begin
                rdata_q <= ch_rd_w[addr[7:6]*32 +: 32];
            end
        end
    end

    assign rdata = rdata_q;

endmodule

// ### hdl/tcc_map.vh
`ifndef TCC_MAP_VH
`define TCC_MAP_VH

// ----------------------------------------------------------------
// Address map
// ----------------------------------------------------------------
`define TCC_ADDR_W 8
`define TCC_OFF_CCR 6'h00
`define TCC_OFF_CMR 6'h04
`define TCC_OFF_CV 6'h10
`define TCC_OFF_RA 6'h14
`define TCC_OFF_RB 6'h18
`define TCC_OFF_RC 6'h1c
`define TCC_OFF_SR 6'h20
`define TCC_ADDR_BCR 8'hc0
`define TCC_ADDR_BMR 8'hc4
`define TCC_CH_BLOCK 2'h3

// ----------------------------------------------------------------
// Command bits (channel and block command words)
// ----------------------------------------------------------------
`define TCC_CCR_EN 0
`define TCC_CCR_DIS 1
`define TCC_CCR_SOFTWARE_TRIGGER_COMMAND 2
`define TCC_BCR_SYNC 0

// ----------------------------------------------------------------
// Channel configuration fields
// ----------------------------------------------------------------
`define TCC_CMR_CLKS 2:0
`define TCC_CMR_CLOCK_INVERT 3
`define TCC_CMR_GATE 5:4
`define TCC_CMR_STOP 6
`define TCC_CMR_DIS 7
`define TCC_CMR_EDGE 9:8
`define TCC_CMR_ABSEL 10
`define TCC_CMR_EXTERNAL_EVENT_SELECT 11:10
`define TCC_CMR_EXTERNAL_EVENT_TRIGGER_ENABLE 12
`define TCC_CMR_PROF 14:13
`define TCC_CMR_COMPARE_C_TRIGGER_ENABLE 14
`define TCC_CMR_WAVE 15
`define TCC_CMR_LDA 17:16
`define TCC_CMR_LDB 19:18
`define TCC_CMR_ACPA 17:16
`define TCC_CMR_ACPC 19:18
`define TCC_CMR_BCPB 25:24
`define TCC_CMR_BCPC 27:26

// ----------------------------------------------------------------
// Status bits and reset values
// ----------------------------------------------------------------
`define TCC_SR_COVF 0
`define TCC_SR_LOVR 1
`define TCC_SR_FLAGS_W 8
`define TCC_SR_CLOCK_ENABLED_FLAG 16
`define TCC_CNT_MAX 16'hffff
`define TCC_CNT_ZERO 16'h0000
`define TCC_RST_CMR 32'h0000_0000
`define TCC_RST_BMR 6'h00

`endif

// ### hdl/tcc_sync2.v
// ----------------------------------------------------------------
// Two-stage synchroniser for pin inputs
// ----------------------------------------------------------------
module tcc_sync2 #(
    parameter W = 9
) (
    // Clock, reset and freeze
    input wire clk,
    input wire rst,
    input wire ce,
    // Asynchronous levels in, synchronous levels out
    input wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);

    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    // The first stage is read only by the second stage.
    always @(posedge clk) begin
        if (rst) begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
        end else if (ce) begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule

// ### hdl/tcc_clksel.v
`include "tcc_map.vh"

// ----------------------------------------------------------------
// Counting clock selection, inversion, gating and edge detection
// ----------------------------------------------------------------
module tcc_clksel (
    // Clock, reset and freeze
    input wire clk,
    input wire rst,
    input wire ce,
    // Candidate clock levels, all on the master clock already
    input wire [4:0] int_clk,
    input wire [2:0] xc,
    // Configuration
    input wire [2:0] sel,
    input wire invert,
    input wire [1:0] gate_sel,
    // One master cycle per active counting edge
    output wire tick
);

    wire [7:0] cand = {xc, int_clk};
    wire lvl = cand[sel] ^ invert;
    wire gate_ok = (gate_sel == 2'h0) ? 1'b1 : xc[gate_sel - 2'h1];
    reg prev_q;

    // Previous level of the selected, possibly inverted, clock.
    always @(posedge clk) begin
        if (rst) begin
            prev_q <= 1'b0;
        end else if (ce) begin
            prev_q <= lvl;
        end
    end

    // Rising edge of the selected level, let through only while the gate is high.
    assign tick = ce & lvl & ~prev_q & gate_ok;

endmodule

// ### test/tcc_props.sv
// ----------------------------------------------------------------
// Port checker for the timer block
// ----------------------------------------------------------------
module tcc_props (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    // Line enables
    input wire logic [2:0] channel_io_a_oe,
    input wire logic [2:0] channel_io_b_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    a_rdata_idle: assert property (ce && !rd |=> rdata == 32'h0)
        else $error("read data not zero outside a read");
    a_count_width: assert property (ce && rd && addr[5:0] == 6'h10 |=> rdata[31:16] == 16'h0)
        else $error("count value wider than sixteen bits");
    a_status_layout: assert property (ce && rd && addr[5:0] == 6'h20 |=>
        rdata[31:17] == 15'h0 && rdata[15:8] == 8'h0)
        else $error("status reserved bits set");
    a_cmd_reads_zero: assert property (ce && rd && addr[5:0] == 6'h00 |=> rdata == 32'h0)
        else $error("command word read back nonzero");
    a_oe_follow: assert property (ce && wr && addr == 8'h04 |=>
        ##1 channel_io_a_oe[0] == $past(wdata[15], 2))
        else $error("line A enable does not follow mode bit");
    a_oe_steady: assert property (!$past(rst) && $changed(channel_io_a_oe) |->
        $past(ce && wr && addr[5:0] == 6'h04, 2))
        else $error("line A enable moved without a mode write");
    a_b_in_capture: assert property (ce && wr && addr == 8'h04 && !wdata[15] |=>
        ##1 !channel_io_b_oe[0])
        else $error("line B driven in capture mode");
    a_routing_back: assert property (ce && wr && addr == 8'hc4
        ##1 ce && rd && addr == 8'hc4 |=> rdata == {26'h0, $past(wdata[5:0], 2)})
        else $error("clock routing read back wrong");
    a_disable_wins: assert property (ce && wr && addr == 8'h00 && wdata[1]
        ##1 ce && rd && addr == 8'h20 |=> !rdata[16])
        else $error("clock still enabled after disable");

    c_count_read: cover property (ce && rd && addr == 8'h10);
    c_wave_mode: cover property (channel_io_a_oe[0]);
    c_soft_trig: cover property (ce && wr && addr == 8'h00 && wdata[2]);
endmodule

bind tcc_top tcc_props i_props (.clk, .rst, .ce, .addr, .wdata, .wr, .rd, .rdata,
    .channel_io_a_oe, .channel_io_b_oe);

// ### test/tcc_pins.sv
// ----------------------------------------------------------------
// Far side: external clock pin and line A source
// ----------------------------------------------------------------
module tcc_pins (
    // Master clock and commands
    input wire logic clk,
    input wire logic go,
    input wire logic a_cmd,
    // Lines seen by the block
    output logic [2:0] pin = 3'h0,
    output logic a_lvl = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;

    // slow pin levels
    // A burst gives four pulses; each level lasts two cycles at least, the pin rests low.
    always @(posedge clk) begin
        a_lvl <= a_cmd;
        if (go && cnt == 0)
            cnt <= 23;
        else if (cnt != 0)
            cnt <= cnt - 1;
        pin <= {2'b00, cnt != 0 && cnt % 6 < 3};
    end
endmodule

// ### test/tcc_top_tb.sv
// ----------------------------------------------------------------
// Timer block testbench
// ----------------------------------------------------------------
module tcc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, wr = 0, rd = 0, go = 0, a_cmd = 0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [4:0] ic = 5'h00;
    logic [2:0] pin, a_o, a_oe, b_o, b_oe;
    logic a_lvl;
    wire [31:0] rdata;
    int err_count = 0, num_checks = 0;

    // Line A level is resolved from the block's enable and the far side; line B comes only from the block's own drive.
    tcc_top i_dut (.clk(clk), .rst(rst), .ce(1'b1), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .internal_clock(ic), .external_clock_pin(pin),
        .channel_io_a_i(a_oe & a_o | ~a_oe & {2'b00, a_lvl}), .channel_io_a_o(a_o),
        .channel_io_a_oe(a_oe), .channel_io_b_i(b_oe & b_o), .channel_io_b_o(b_o),
        .channel_io_b_oe(b_oe));
    tcc_pins i_pins (.clk(clk), .go(go), .a_cmd(a_cmd), .pin(pin), .a_lvl(a_lvl));

    // Master clock at 125 MHz.
    initial forever #4 clk = ~clk;

    task automatic chk(input logic [31:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h, want %h", $time, got, exp);
        end
    endtask
    // The write strobe stays up until the next task, so writes may run back to back.
    task automatic wr32(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1;
        @(posedge clk);
    endtask
    task automatic idle(input int n);
        wr <= 0;
        repeat (n) @(posedge clk);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, m = 32'hffffffff);
        addr <= a;
        wr <= 0;
        rd <= 1;
        @(posedge clk);
        rd <= 0;
        @(negedge clk);
        chk(rdata & m, e);
        @(posedge clk);
    endtask
    // n counting edges on internal clock 2.
    task automatic tick(input int n);
        repeat (n) begin
            ic[1] <= 1;
            idle(2);
            ic[1] <= 0;
            idle(2);
        end
    endtask
    task automatic line(input logic v);
        a_cmd <= v;
        idle(6);
    endtask

    task automatic t_reset;
        rd_chk(8'h04, 32'h0);
        rd_chk(8'h10, 32'h0);
        rd_chk(8'h20, 32'h0);
        rd_chk(8'h00, 32'h0);
        rd_chk(8'h08, 32'h0);
        $display("test reset values done");
    endtask
    task automatic t_count;
        wr32(8'h04, 32'h1);
        wr32(8'h00, 32'h1);
        tick(5);
        rd_chk(8'h10, 32'h5);
        wr32(8'h00, 32'h4);
        rd_chk(8'h10, 32'h5);
        tick(3);
        rd_chk(8'h10, 32'h2);
        wr32(8'hc0, 32'h1);
        tick(3);
        rd_chk(8'h10, 32'h2);
        wr32(8'h00, 32'h3);
        rd_chk(8'h20, 32'h0, 32'h10000);
        tick(2);
        rd_chk(8'h10, 32'h2);
        wr32(8'h00, 32'h1);
        rd_chk(8'h20, 32'h10000, 32'h10000);
        tick(1);
        rd_chk(8'h10, 32'h3);
        $display("test counting and control done");
    endtask
    task automatic t_wave;
        wr32(8'h1c, 32'h3);
        // Compares A and B set both lines at count zero; the event sits on a clock, so B drives.
        wr32(8'h04, 32'h0101c401);
        wr32(8'h00, 32'h5);
        tick(6);
        rd_chk(8'h10, 32'h1);
        chk({26'h0, b_oe, a_oe}, 32'h9);
        chk({26'h0, b_o, a_o}, 32'h9);
        wr32(8'h04, 32'he001);
        tick(3);
        wr32(8'h00, 32'h4);
        tick(1);
        rd_chk(8'h10, 32'h3);
        wr32(8'h04, 32'h8001);
        wr32(8'h00, 32'h4);
        tick(6);
        rd_chk(8'h10, 32'h5);
        wr32(8'h04, 32'ha001);
        tick(1);
        wr32(8'h00, 32'h4);
        tick(1);
        rd_chk(8'h10, 32'h5);
        $display("test count profiles done");
    endtask
    task automatic t_capture;
        wr32(8'h04, 32'h90001);
        wr32(8'h00, 32'h4);
        tick(5);
        line(1);
        tick(2);
        line(0);
        tick(1);
        line(1);
        rd_chk(8'h20, 32'h2, 32'h2);
        rd_chk(8'h14, 32'h7);
        rd_chk(8'h18, 32'h6);
        $display("test capture done");
    endtask
    task automatic t_ext;
        wr32(8'hc4, 32'h39);
        rd_chk(8'hc4, 32'h39);
        wr32(8'hc4, 32'h0);
        wr32(8'h44, 32'h5);
        wr32(8'h40, 32'h1);
        go <= 1;
        idle(1);
        go <= 0;
        idle(40);
        // The block-wide trigger from the counting test is still pending, so edge one zeroes.
        rd_chk(8'h50, 32'h3);
        $display("test external clock done");
    endtask

    task automatic close_out;
        $display("checks %0d, mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Main sequence after a ten cycle reset.
    initial begin
        repeat (10) @(posedge clk);
        rst <= 0;
        t_reset;
        t_count;
        t_wave;
        t_capture;
        t_ext;
        close_out;
    end
    // The tests need well under 1000 cycles, so a hang is cut at 20 us.
    initial begin
        #20000;
        err_count++;
        $display("CHECK FAILED at %0t: run did not finish", $time);
        close_out;
    end
endmodule
